// file: hw/scc_pkg.sv
// --------------------------------------------------------------------
// strap capture constants
// --------------------------------------------------------------------
package scc_pkg;
	// apb address decode, byte addresses of the three words
	localparam int unsigned SCC_ADDR_W          = 12;
	localparam logic [11:0] SCC_STRAP_VALUE_OFS = 12'h000; // read only
	localparam logic [11:0] SCC_CONFIG_OFS      = 12'h004; // read/write
	localparam logic [11:0] SCC_STATUS_OFS      = 12'h008; // read only

	// strap bit positions in the strap-value word
	localparam int unsigned SCC_STRAP_N    = 5;
	localparam int unsigned SCC_S_REGULATOR = 0; // regulator_voltage_strap
	localparam int unsigned SCC_S_BOOT_SEL  = 1; // boot_select_strap
	localparam int unsigned SCC_S_DL_QUAL   = 2; // download_qualify_strap
	localparam int unsigned SCC_S_LOG_EDGE  = 3; // log_and_edge_strap
	localparam int unsigned SCC_S_EDGE_LOW  = 4; // edge_select_low_strap

	// weak pull direction per strap, one means pull-up
	localparam logic [4:0] SCC_STRAP_PULL_UP = 5'h1a;

	// configuration word fields
	localparam int unsigned SCC_CFG_W            = 5;
	localparam int unsigned SCC_CFG_VOLT_OVR     = 0; // use firmware volt
	localparam int unsigned SCC_CFG_VOLT_1V8     = 1; // one selects 1.8 v
	localparam int unsigned SCC_CFG_SDIO_OVR     = 2; // use firmware edges
	localparam int unsigned SCC_CFG_SDIO_IN_RISE = 3; // input on rising
	localparam int unsigned SCC_CFG_SDIO_OUT_RISE = 4; // output on rising
	localparam logic [4:0]  SCC_CFG_RESET        = 5'h00;

	// status word fields
	localparam int unsigned SCC_ST_VOLT_1V8  = 0;
	localparam int unsigned SCC_ST_BOOT_FLASH = 1;
	localparam int unsigned SCC_ST_BOOT_DL   = 2;
	localparam int unsigned SCC_ST_LOG_EN    = 3;
	localparam int unsigned SCC_ST_IN_RISE   = 4;
	localparam int unsigned SCC_ST_OUT_RISE  = 5;
	localparam int unsigned SCC_ST_CAPTURED  = 6;
	localparam int unsigned SCC_ST_CHIP_EN   = 7;
	localparam int unsigned SCC_ST_BOOT_UNDEF = 8;

	// pull settle time before the latches close
	localparam int unsigned SCC_CLK_MHZ   = 40;
	localparam int unsigned SCC_SETTLE_NS = 200;
	localparam int unsigned SCC_SETTLE_RAW =
		(SCC_SETTLE_NS * SCC_CLK_MHZ + 999) / 1000;
	localparam int unsigned SCC_SETTLE_CYCLES =
		(SCC_SETTLE_RAW < 1) ? 1 : SCC_SETTLE_RAW;

	// capture sequence
	typedef enum logic [0:0] {
		SCC_SETTLE,
		SCC_FROZEN
	} scc_state_e;
endpackage

// file: hw/scc_strap_capture.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module scc_strap_capture
	import scc_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = SCC_SETTLE_CYCLES // pull settle
) (
	input  wire logic        pclk,                    // apb clock, 40 mhz
	input  wire logic        presetn,                 // async reset, low
	input  wire logic        psel,                    // apb select
	input  wire logic        penable,                 // apb access phase
	input  wire logic        pwrite,                  // apb write
	input  wire logic [11:0] paddr,                   // apb byte address
	input  wire logic [31:0] pwdata,                  // apb write data
	output logic      [31:0] prdata,                  // apb read data
	output logic             pready,                  // apb ready
	output logic             pslverr,                 // apb error
	input  wire logic        chip_enable,             // chip enable, high
	input  wire logic        regulator_voltage_strap, // strap pin level
	input  wire logic        boot_select_strap,       // strap pin level
	input  wire logic        download_qualify_strap,  // strap pin level
	input  wire logic        log_and_edge_strap,      // strap pin level
	input  wire logic        edge_select_low_strap,   // strap pin level
	output logic      [4:0]  strap_pull_en,           // weak pulls active
	output logic      [4:0]  strap_pull_up,           // pull direction
	output logic             pins_functional,         // pins to normal mux
	output logic             vddio_sel_1v8,           // regulator at 1.8 v
	output logic             boot_from_flash,         // flash boot
	output logic             boot_download,           // serial download
	output logic             boot_log_enable,         // log on first tx
	output logic             sdio_in_rise,            // sample on rising
	output logic             sdio_out_rise,           // launch on rising
	output logic             config_valid             // settings usable
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);

	// firmware value wins over the strap when its override is set
	function automatic logic scc_pick(input logic ovr, input logic fw,
			input logic strap);
		scc_pick = ovr ? fw : strap;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	scc_state_e         state_q, state_d;   // capture sequence
	logic [CNT_W-1:0]   cnt_q, cnt_d;       // settle counter
	logic [4:0]         strap_q, strap_d;   // latched strap bits
	logic [4:0]         cfg_q, cfg_d;       // firmware config
	logic               pull_q, pull_d;     // pulls on
	logic               func_q, func_d;     // normal pin function
	logic [5:0]         set_q, set_d;       // decoded settings
	logic               valid_q, valid_d;   // settings usable
	logic               rdy_q, rdy_d;       // apb ready
	logic               err_q, err_d;       // apb error
	logic [31:0]        rdata_q, rdata_d;   // apb read data
	logic [4:0]         pins;               // strap pins as one word
	logic               setup;              // apb setup phase
	logic               wr_take;            // write completes this edge
	logic               boot_undef;         // select low, qualify high

	assign pins = {edge_select_low_strap, log_and_edge_strap,
		download_qualify_strap, boot_select_strap,
		regulator_voltage_strap};
	assign setup   = psel & ~penable;
	assign wr_take = psel & penable & rdy_q & pwrite;
	assign boot_undef = ~strap_q[SCC_S_BOOT_SEL] & strap_q[SCC_S_DL_QUAL];

	// ----------------------------------------------------------------
	// capture sequence
	// ----------------------------------------------------------------
	// pulls stay on through reset and the settle count; a low chip
	// enable stalls the count, so the latches never close while the
	// chip is held disabled
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		strap_d = strap_q;
		pull_d  = pull_q;
		func_d  = func_q;
		case (state_q)
			SCC_SETTLE: begin
				if (chip_enable) begin
					if (cnt_q == CNT_W'(SETTLE_CYCLES - 1)) begin
						strap_d = pins;
						pull_d  = 1'b0;
						func_d  = 1'b1;
						state_d = SCC_FROZEN;
					end else begin
						cnt_d = cnt_q + CNT_W'(1);
					end
				end
			end
			SCC_FROZEN: begin
				// latches hold until the next power-on reset
				strap_d = strap_q;
			end
			default: begin
				state_d = SCC_SETTLE;
			end
		endcase
	end

	// pull enable resets high, so the pulls act during reset itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SCC_SETTLE;
			cnt_q   <= '0;
			strap_q <= SCC_STRAP_PULL_UP;
			pull_q  <= 1'b1;
			func_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			strap_q <= strap_d;
			pull_q  <= pull_d;
			func_q  <= func_d;
		end
	end

	// ----------------------------------------------------------------
	// decoded settings
	// ----------------------------------------------------------------
	// one cycle behind the strap latch and config word
	always_comb begin
		set_d = '0;
		set_d[SCC_ST_VOLT_1V8] = scc_pick(cfg_q[SCC_CFG_VOLT_OVR],
			cfg_q[SCC_CFG_VOLT_1V8], strap_q[SCC_S_REGULATOR]);
		set_d[SCC_ST_BOOT_FLASH] = strap_q[SCC_S_BOOT_SEL];
		set_d[SCC_ST_BOOT_DL] = ~strap_q[SCC_S_BOOT_SEL]
			& ~strap_q[SCC_S_DL_QUAL];
		set_d[SCC_ST_LOG_EN] = strap_q[SCC_S_LOG_EDGE];
		set_d[SCC_ST_IN_RISE] = scc_pick(cfg_q[SCC_CFG_SDIO_OVR],
			cfg_q[SCC_CFG_SDIO_IN_RISE], strap_q[SCC_S_LOG_EDGE]);
		set_d[SCC_ST_OUT_RISE] = scc_pick(cfg_q[SCC_CFG_SDIO_OVR],
			cfg_q[SCC_CFG_SDIO_OUT_RISE], strap_q[SCC_S_EDGE_LOW]);
		valid_d = (state_q == SCC_FROZEN) & chip_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_q   <= '0;
			valid_q <= 1'b0;
		end else begin
			set_q   <= set_d;
			valid_q <= valid_d;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// answer is prepared in the setup cycle, so every access phase
	// lasts exactly one cycle and all bus outputs come from flops
	always_comb begin
		rdy_d   = setup;
		err_d   = 1'b0;
		rdata_d = '0;
		cfg_d   = cfg_q;
		if (setup) begin
			case (paddr)
				SCC_STRAP_VALUE_OFS: begin
					rdata_d[SCC_STRAP_N-1:0] = strap_q;
					err_d = pwrite; // read only word
				end
				SCC_CONFIG_OFS: begin
					rdata_d[SCC_CFG_W-1:0] = cfg_q;
					err_d = pwrite & ~chip_enable;
				end
				SCC_STATUS_OFS: begin
					rdata_d[SCC_ST_OUT_RISE:SCC_ST_VOLT_1V8] = set_q;
					rdata_d[SCC_ST_CAPTURED]   = func_q;
					rdata_d[SCC_ST_CHIP_EN]    = chip_enable;
					rdata_d[SCC_ST_BOOT_UNDEF] = boot_undef;
					err_d = pwrite;
				end
				default: begin
					err_d = 1'b1; // unmapped address
				end
			endcase
		end
		// config takes effect only on the completing edge
		if (wr_take && paddr == SCC_CONFIG_OFS && chip_enable) begin
			cfg_d = pwdata[SCC_CFG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= '0;
			cfg_q   <= SCC_CFG_RESET;
		end else begin
			rdy_q   <= rdy_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
			cfg_q   <= cfg_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata          = rdata_q;
	assign pready          = rdy_q;
	assign pslverr         = err_q;
	assign strap_pull_en   = {5{pull_q}};
	assign strap_pull_up   = SCC_STRAP_PULL_UP;
	assign pins_functional = func_q;
	assign vddio_sel_1v8   = set_q[SCC_ST_VOLT_1V8];
	assign boot_from_flash = set_q[SCC_ST_BOOT_FLASH];
	assign boot_download   = set_q[SCC_ST_BOOT_DL];
	assign boot_log_enable = set_q[SCC_ST_LOG_EN];
	assign sdio_in_rise    = set_q[SCC_ST_IN_RISE];
	assign sdio_out_rise   = set_q[SCC_ST_OUT_RISE];
	assign config_valid    = valid_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	strap_read_a: assert property (
		setup && !pwrite && paddr == SCC_STRAP_VALUE_OFS
		|=> prdata[SCC_STRAP_N-1:0] == $past(strap_q)
		&& prdata[31:SCC_STRAP_N] == '0 && pready)
		else $error("strap word read wrong");
	strap_frozen_a: assert property (
		state_q == SCC_FROZEN |=> $stable(strap_q))
		else $error("latched straps changed");
	capture_pins_a: assert property (
		state_q == SCC_SETTLE ##1 state_q == SCC_FROZEN
		|-> strap_q == $past(pins))
		else $error("capture missed pin levels");
	pulls_held_a: assert property (
		state_q == SCC_SETTLE |-> strap_pull_en == '1
		&& !pins_functional)
		else $error("pulls off before capture");
	pins_release_a: assert property (
		state_q == SCC_FROZEN |-> strap_pull_en == '0
		&& pins_functional)
		else $error("pins not returned to function");
	volt_decode_a: assert property (
		##1 !cfg_q[SCC_CFG_VOLT_OVR] && $stable(strap_q)
		|=> vddio_sel_1v8 == $past(strap_q[SCC_S_REGULATOR]))
		else $error("regulator select wrong");
	boot_decode_a: assert property (
		##1 $stable(strap_q)
		|=> boot_from_flash == $past(strap_q[SCC_S_BOOT_SEL])
		&& boot_download == (!$past(strap_q[SCC_S_BOOT_SEL])
		&& !$past(strap_q[SCC_S_DL_QUAL]))
		&& boot_log_enable == $past(strap_q[SCC_S_LOG_EDGE]))
		else $error("boot decode wrong");
	sdio_decode_a: assert property (
		##1 !cfg_q[SCC_CFG_SDIO_OVR] && $stable(strap_q)
		&& $stable(cfg_q)
		|=> sdio_in_rise == $past(strap_q[SCC_S_LOG_EDGE])
		&& sdio_out_rise == $past(strap_q[SCC_S_EDGE_LOW]))
		else $error("sdio edge decode wrong");
	cfg_write_a: assert property (
		wr_take && paddr == SCC_CONFIG_OFS && chip_enable
		|=> cfg_q == $past(pwdata[SCC_CFG_W-1:0])
		##1 (!cfg_q[SCC_CFG_VOLT_OVR]
		|| vddio_sel_1v8 == cfg_q[SCC_CFG_VOLT_1V8]))
		else $error("override not applied");
	disabled_a: assert property (
		!chip_enable |=> !config_valid && ($stable(state_q)
		|| $past(state_q) == SCC_FROZEN))
		else $error("ran while disabled");
	apb_ready_a: assert property (
		setup |=> pready)
		else $error("bus answer missing");
	cfg_locked_a: assert property (
		wr_take && !chip_enable |=> $stable(cfg_q))
		else $error("config written while disabled");
	valid_on_a: assert property (
		state_q == SCC_FROZEN && chip_enable |=> config_valid)
		else $error("settings not valid when running");

	capture_c:  cover property (state_q == SCC_SETTLE ##1
		state_q == SCC_FROZEN);
	override_c: cover property (wr_take && paddr == SCC_CONFIG_OFS);
	read_c:     cover property (setup && paddr == SCC_STATUS_OFS);
	stall_c:    cover property (state_q == SCC_SETTLE && !chip_enable);
	undef_c:    cover property (boot_undef && valid_q);

endmodule

`default_nettype wire

// file: tb/scc_strap_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// strap pins as the board sees them: host gpio, pulls, or noise
// ------------------------------------------------------------
module scc_strap_model (
	input  wire logic       pclk,     // system clock
	input  wire logic       host_en,  // host gpio drives the pins
	input  wire logic [4:0] host_val, // levels the host drives
	input  wire logic [4:0] pull_en,  // device weak pulls active
	input  wire logic [4:0] pull_up,  // device pull direction
	output logic      [4:0] pins      // resolved pin levels
);
	logic [4:0] float_q = 5'h00; // level of an undriven pin

	// an undriven pin must not hold its last level, so it flips
	always @(posedge pclk) begin
		float_q <= ~pins;
	end

	// the host overrides the weak pulls; with neither, noise
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (host_en) begin
				pins[i] = host_val[i];
			end else if (pull_en[i]) begin
				pins[i] = pull_up[i];
			end else begin
				pins[i] = float_q[i];
			end
		end
	end
endmodule

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	import scc_pkg::*;
	// e holds {boot undefined, out, in, log, download, flash, 1.8 v}
	typedef struct packed {logic host; logic [4:0] v;
		logic [6:0] e;} scc_row_s;
	localparam logic [4:0] DFLT = 5'h1a; // pulls: 0,2 down; 1,3,4 up
	localparam int         SET  = 8;     // settle edges before capture

	logic        pclk, presetn, psel, penable, pwrite, chip_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, host_en, cvalid, pins_fn;
	logic [4:0]  host_val, pins, pull_en, pull_up, s;
	logic        vddio, flash, dl, logen, in_r, out_r;
	int          err_total, total_checks, n;
	scc_row_s    rows [6] = '{'{1'b0, 5'h00, 7'h3a},
		'{1'b1, 5'h00, 7'h04}, '{1'b1, 5'h1f, 7'h3b},
		'{1'b1, 5'h04, 7'h40}, '{1'b1, 5'h09, 7'h1d},
		'{1'b1, 5'h12, 7'h22}};

	always #12.5 pclk = ~pclk;

	scc_strap_capture #(.SETTLE_CYCLES(SET)) i_scc_strap_capture (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
		.regulator_voltage_strap(pins[0]), .boot_select_strap(pins[1]),
		.download_qualify_strap(pins[2]), .log_and_edge_strap(pins[3]),
		.edge_select_low_strap(pins[4]), .strap_pull_en(pull_en),
		.strap_pull_up(pull_up), .pins_functional(pins_fn),
		.vddio_sel_1v8(vddio), .boot_from_flash(flash),
		.boot_download(dl), .boot_log_enable(logen),
		.sdio_in_rise(in_r), .sdio_out_rise(out_r), .config_valid(cvalid));

	scc_strap_model i_scc_strap_model (.pclk(pclk), .host_en(host_en),
		.host_val(host_val), .pull_en(pull_en), .pull_up(pull_up),
		.pins(pins));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen,
			input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; request held until pready seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		chk("pready", 32'(pready), 32'h0000_0001);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// power-on: pins set during reset, then count edges to the capture
	task automatic boot(input logic he, input logic [4:0] hv,
			input logic ce);
		presetn <= 1'b0;
		host_en <= he;
		host_val <= hv;
		chip_enable <= ce;
		repeat (5) @(posedge pclk);
		chk("pull_en_rst", 32'(pull_en), 32'h0000_001f);
		chk("pull_up_rst", 32'(pull_up), 32'(DFLT));
		chk("pins_fn_rst", 32'(pins_fn), 32'h0000_0000);
		presetn <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pins_fn !== 1'b1 && n < 40);
		repeat (2) @(posedge pclk);
	endtask

	// decoded settings and status word against the expected value
	task automatic check_decode(input logic [6:0] e);
		chk("settings", 32'({out_r, in_r, logen, dl, flash, vddio}),
			32'(e[5:0]));
		apb(1'b0, SCC_STRAP_VALUE_OFS, 32'h0000_0000);
		chk("strap_reg", rd, 32'(s));
		apb(1'b0, SCC_STATUS_OFS, 32'h0000_0000);
		chk("status", 32'(rd[8:0]),
			32'({e[6], 2'b11, e[5:0]}));
	endtask

	task automatic conclude();
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// stimulus: table rows first, then the awkward cases
	// ------------------------------------------------------------
	initial begin
		{pclk, presetn, psel, penable, pwrite, host_en} = 6'b000000;
		{paddr, pwdata, host_val, chip_enable} = '0;
		err_total = 0;
		total_checks = 0;
		foreach (rows[i]) begin
			boot(rows[i].host, rows[i].v, 1'b1);
			s = rows[i].host ? rows[i].v : DFLT;
			chk("settle", n, SET + 1);
			chk("cfg_valid", 32'(cvalid), 32'h0000_0001);
			check_decode(rows[i].e);
		end
		// pins released and wandering: latched bits must not move
		host_en <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("pull_off", 32'({pull_en, pins_fn}), 32'h0000_0001);
		check_decode(7'h22);
		// firmware override of voltage and sdio edges, boot kept
		apb(1'b1, SCC_CONFIG_OFS, 32'h0000_000f);
		chk("cfg_wr_err", 32'(er), 32'h0000_0000);
		repeat (3) @(posedge pclk);
		chk("override", 32'({vddio, in_r, out_r, flash, dl, logen}),
			32'h0000_0034);
		apb(1'b0, SCC_CONFIG_OFS, 32'h0000_0000);
		chk("cfg_rd", rd, 32'h0000_000f);
		// read-only words refuse writes, unmapped word refused
		apb(1'b1, SCC_STRAP_VALUE_OFS, 32'hffff_ffff);
		chk("ro_wr0", 32'(er), 32'h0000_0001);
		apb(1'b1, SCC_STATUS_OFS, 32'hffff_ffff);
		chk("ro_wr8", 32'(er), 32'h0000_0001);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		chk("unmapped", 32'(er), 32'h0000_0001);
		apb(1'b0, SCC_STRAP_VALUE_OFS, 32'h0000_0000);
		chk("strap_kept", rd, 32'h0000_0012);
		// chip enable low: config writes refused, settings not valid
		chip_enable <= 1'b0;
		apb(1'b1, SCC_CONFIG_OFS, 32'h0000_0000);
		chk("ce_wr_err", 32'(er), 32'h0000_0001);
		apb(1'b0, SCC_CONFIG_OFS, 32'h0000_0000);
		chk("ce_cfg", rd, 32'h0000_000f);
		chk("ce_valid", 32'(cvalid), 32'h0000_0000);
		// power-on with chip enable low stalls the capture
		boot(1'b1, 5'h05, 1'b0);
		chk("ce_stall", 32'(pins_fn), 32'h0000_0000);
		apb(1'b0, SCC_CONFIG_OFS, 32'h0000_0000);
		chk("cfg_rst", rd, 32'(SCC_CFG_RESET));
		chip_enable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cvalid !== 1'b1 && n < 40);
		s = 5'h05;
		check_decode(7'h41);
		conclude();
	end

	// watchdog: the whole run needs well under two thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		conclude();
	end
endmodule

`default_nettype wire
